// ===== rtl/wdog_top.sv
// Watchdog supervisor: counter, mode/command registers, overflow event, reset routing.
// Assumes the register port is driven from logic on CLK_SYS_I; halt status comes from the core.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Out of reset the watchdog is enabled and counting without software.
// - Writing B1h to the command register stops the watchdog.
// - Writing 4Eh to the command register restarts the count from zero.
// - With reset-connect set, an overflow drives the device reset request.
// - Light-halt run bit: 0 halts counting in light halt, 1 keeps running.
// - Counting continues while the external bus is released.
// - One state is two fast clocks; the counter advances once per state.
module wdog_top (
	input  wire logic                 CLK_SYS_I,      // Fast clock, 10 MHz
	input  wire logic                 RESETN_I,       // Asynchronous reset, active low
	input  wire logic                 CE_I,           // Clock enable, freezes all state when low
	input  wire wdog_pkg::reg_req_t   REG_REQ_I,      // Register address, data and strobes
	input  wire logic                 LIGHT_HALT_I,   // Core is in light halt mode
	input  wire logic                 BUS_RELEASE_I,  // External bus is released
	output var  logic [7:0]           REG_RDATA_O,    // Read data, cycle after the read strobe
	output var  logic                 OVF_PULSE_O,    // One-cycle overflow event
	output var  logic                 RESET_REQ_O,    // Overflow routed to device reset
	output logic                      IRQ_O           // Level interrupt
);
	import wdog_pkg::*;

	mode_t             mode_r;
	logic              run_r;
	logic [CNT_W-1:0]  cnt_r;
	logic              div_r;
	logic [7:0]        stat_r;
	logic [7:0]        mask_r;

	// Bus release only documents that counting goes on; nothing here gates on it
	wire bus_rel_unused = BUS_RELEASE_I;

	wire wr_mode = CE_I && REG_REQ_I.wr && (REG_REQ_I.addr == MODE_OFS);
	wire wr_cmd  = CE_I && REG_REQ_I.wr && (REG_REQ_I.addr == CMD_OFS);
	wire wr_stat = CE_I && REG_REQ_I.wr && (REG_REQ_I.addr == STAT_OFS);
	wire wr_mask = CE_I && REG_REQ_I.wr && (REG_REQ_I.addr == MASK_OFS);
	wire cmd_dis = wr_cmd && (REG_REQ_I.wdata == CMD_DISABLE);
	wire cmd_clr = wr_cmd && (REG_REQ_I.wdata == CMD_CLEAR);

	function automatic logic [CNT_W-1:0] period_last(input logic [1:0] code);
		logic [CNT_W:0] p;
		p = '0;
		unique case (code)
			2'b00: p = (CNT_W+1)'(1) << PER_EXP0;
			2'b01: p = (CNT_W+1)'(1) << PER_EXP1;
			2'b10: p = (CNT_W+1)'(1) << PER_EXP2;
			2'b11: p = (CNT_W+1)'(1) << PER_EXP3;
		endcase
		period_last = p[CNT_W-1:0] - CNT_W'(1);
	endfunction

	// Field placement lives in one spot so write and readback cannot drift apart
	function automatic logic [7:0] mode_pack(input mode_t m);
		logic [7:0] b;
		b                  = 8'h00;
		b[EN_POS]          = m.en;
		b[PSH_POS:PSL_POS] = m.per;
		b[LHR_POS]         = m.lhr;
		b[RCON_POS]        = m.rcon;
		mode_pack          = b;
	endfunction

	function automatic mode_t mode_unpack(input logic [7:0] b);
		mode_t m;
		m.en        = b[EN_POS];
		m.per       = b[PSH_POS:PSL_POS];
		m.lhr       = b[LHR_POS];
		m.rcon      = b[RCON_POS];
		mode_unpack = m;
	endfunction

	wire [CNT_W-1:0] last_cnt = period_last(mode_r.per);
	wire halted    = LIGHT_HALT_I && !mode_r.lhr;
	wire state_tick = CE_I && div_r;
	wire counting  = run_r && !halted;
	// A disable in the same cycle suppresses the event as well as the count
	wire ovf_hit   = state_tick && counting && !cmd_clr && !cmd_dis && (cnt_r == last_cnt);

	// State clock divider: one tick every second fast clock
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I)
			div_r <= 1'b0;
		else if (CE_I)
			div_r <= ~div_r;
	end

	// Mode register; changed only by mode writes, the commands leave the enable bit alone
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mode_r <= '{en: MODE_RST[EN_POS], per: MODE_RST[PSH_POS:PSL_POS],
			            lhr: MODE_RST[LHR_POS], rcon: MODE_RST[RCON_POS]};
		end else if (wr_mode) begin
			mode_r <= mode_unpack(REG_REQ_I.wdata);
		end
	end

	// Run flag: disable code or a mode write with enable clear stops; a mode write with enable set restarts
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I)
			run_r <= 1'b1;
		else if (cmd_dis)
			run_r <= 1'b0;
		else if (wr_mode && REG_REQ_I.wdata[EN_POS])
			run_r <= 1'b1;
		else if (wr_mode)
			run_r <= 1'b0;
	end

	// Counter; clear wins over a tick in the same cycle
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I)
			cnt_r <= '0;
		else if (cmd_clr || cmd_dis)
			cnt_r <= '0;
		else if (ovf_hit)
			cnt_r <= '0;
		else if (state_tick && counting)
			cnt_r <= cnt_r + CNT_W'(1);
	end

	// Overflow pulse and reset routing
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			OVF_PULSE_O <= 1'b0;
			RESET_REQ_O <= 1'b0;
		end else if (CE_I) begin
			OVF_PULSE_O <= ovf_hit;
			RESET_REQ_O <= ovf_hit && mode_r.rcon;
		end
	end

	// Sticky status (set wins over write-one-clear) and mask
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			stat_r <= STAT_RST;
			mask_r <= STAT_RST;
		end else begin
			if (wr_stat)
				stat_r[ST_OVF] <= stat_r[ST_OVF] & ~REG_REQ_I.wdata[ST_OVF];
			if (ovf_hit)
				stat_r[ST_OVF] <= 1'b1;
			if (wr_mask)
				mask_r <= {7'h00, REG_REQ_I.wdata[ST_OVF]};
		end
	end

	assign IRQ_O = |(stat_r & mask_r);

	// Read data; command register is write-only and reads zero
	wire [7:0] mode_rd = mode_pack(mode_r) & MODE_WMASK;
	logic [7:0] rdata_nxt;
	always_comb begin
		rdata_nxt = 8'h00;
		if (REG_REQ_I.addr == MODE_OFS)
			rdata_nxt = mode_rd;
		else if (REG_REQ_I.addr == STAT_OFS)
			rdata_nxt = stat_r;
		else if (REG_REQ_I.addr == MASK_OFS)
			rdata_nxt = mask_r;
	end

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I)
			REG_RDATA_O <= 8'h00;
		else if (CE_I)
			REG_RDATA_O <= REG_REQ_I.rd ? rdata_nxt : 8'h00;
	end

	// Assertions
	a_clear_zeroes_count: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		cmd_clr |=> (cnt_r == '0))
		else $error("count not zero after clear");

	a_disable_stops_run: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		cmd_dis |=> !run_r)
		else $error("watchdog still running after disable");

	a_halt_freezes_count: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(halted && !cmd_clr && !cmd_dis) |=> $stable(cnt_r))
		else $error("count moved in light halt");

	a_ovf_one_cycle: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(OVF_PULSE_O && CE_I) |=> !OVF_PULSE_O)
		else $error("overflow pulse longer than one cycle");

	a_ovf_restarts: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		ovf_hit |=> (cnt_r == '0) && OVF_PULSE_O)
		else $error("overflow did not restart count");

	a_reset_routing: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		RESET_REQ_O |-> (OVF_PULSE_O && $past(mode_r.rcon)))
		else $error("reset request without routed overflow");

	a_tick_rate: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(CE_I && state_tick) |=> (CE_I |-> !state_tick))
		else $error("state tick faster than half the fast clock");

	a_count_steps: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(state_tick && counting && !ovf_hit && !cmd_clr && !cmd_dis) |=> (cnt_r == $past(cnt_r) + CNT_W'(1)))
		else $error("counter did not advance on state tick");

	// A state tick that really advances the count
	sequence s_count_tick;
		state_tick && counting && !cmd_clr && !cmd_dis && !ovf_hit;
	endsequence

	// Disable followed by four cycles without a mode write
	sequence s_dis_quiet;
		cmd_dis ##1 (!wr_mode)[*4];
	endsequence

	a_period_value: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		last_cnt == CNT_W'((1 << (PER_EXP0 + 2 * mode_r.per)) - 1))
		else $error("period limit does not match period code");

	a_mode_write_lands: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		wr_mode |=> (mode_r.per == $past(REG_REQ_I.wdata[PSH_POS:PSL_POS])))
		else $error("period code not taken from mode write");

	a_disable_holds: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		s_dis_quiet |=> ((cnt_r == '0) && !run_r))
		else $error("watchdog restarted without a mode write");

	a_stopped_no_ovf: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		!run_r |-> !ovf_hit)
		else $error("overflow while stopped");

	a_enable_write_runs: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(wr_mode && REG_REQ_I.wdata[EN_POS]) |=> run_r)
		else $error("enable write did not start the watchdog");

	a_clear_restarts: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(cmd_clr ##1 s_count_tick) |=> (cnt_r == CNT_W'(1)))
		else $error("count did not restart from zero after clear");

	a_reset_on_ovf: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(ovf_hit && mode_r.rcon) |=> RESET_REQ_O)
		else $error("routed overflow did not request reset");

	a_no_reset_unrouted: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(CE_I && !(ovf_hit && mode_r.rcon)) |=> !RESET_REQ_O)
		else $error("reset request without routing");

	a_halt_run_counts: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(s_count_tick ##0 (LIGHT_HALT_I && mode_r.lhr)) |=> (cnt_r == $past(cnt_r) + CNT_W'(1)))
		else $error("count stopped in light halt with run bit set");

	a_halt_no_ovf: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		halted |-> !ovf_hit)
		else $error("overflow while halted");

	a_bus_release_counts: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(s_count_tick ##0 BUS_RELEASE_I) |=> (cnt_r == $past(cnt_r) + CNT_W'(1)))
		else $error("count stopped during bus release");

	a_cmd_reads_zero: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(CE_I && REG_REQ_I.rd && (REG_REQ_I.addr == CMD_OFS)) |=> (REG_RDATA_O == 8'h00))
		else $error("command register read not zero");

	a_tick_alternates: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(CE_I && !state_tick) |=> (CE_I |-> state_tick))
		else $error("state tick missing after an idle fast clock");

	a_ce_freezes_state: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		!CE_I |=> ($stable(cnt_r) && $stable(run_r) && $stable(div_r) && $stable(stat_r) && $stable(mask_r)))
		else $error("state moved with clock enable low");

	a_ovf_pulse_source: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(OVF_PULSE_O && $past(CE_I)) |-> $past(ovf_hit))
		else $error("overflow pulse without overflow");

	a_status_set_wins: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		ovf_hit |=> stat_r[ST_OVF])
		else $error("status bit not set by overflow");

	a_status_w1c: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(wr_stat && REG_REQ_I.wdata[ST_OVF] && !ovf_hit) |=> !stat_r[ST_OVF])
		else $error("status bit not cleared by writing one");

	a_mask_write_lands: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		wr_mask |=> (mask_r[ST_OVF] == $past(REG_REQ_I.wdata[ST_OVF])))
		else $error("mask bit not taken from write");

endmodule
`default_nettype wire

// ===== rtl/wdog_pkg.sv
// Package for the watchdog supervisor: register map, field layout, codes, periods.
// Assumes a single system clock domain and a simple strobe register port.
package wdog_pkg;

	// Register offsets (byte addresses on the 12-bit register port)
	localparam logic [11:0] MODE_OFS = 12'h0300;
	localparam logic [11:0] CMD_OFS  = 12'h0301;
	localparam logic [11:0] STAT_OFS = 12'h0302;
	localparam logic [11:0] MASK_OFS = 12'h0303;

	// Mode register fields
	localparam int EN_POS   = 7;
	localparam int PSH_POS  = 6;
	localparam int PSL_POS  = 5;
	localparam int LHR_POS  = 2;
	localparam int RCON_POS = 1;
	localparam logic [7:0] MODE_RST = 8'h80;
	localparam logic [7:0] MODE_WMASK = 8'hE6;

	// Command codes
	localparam logic [7:0] CMD_DISABLE = 8'hB1;
	localparam logic [7:0] CMD_CLEAR   = 8'h4E;

	// Overflow exponents in state clocks for period codes 00..11
	localparam int PER_EXP0 = 15;
	localparam int PER_EXP1 = 17;
	localparam int PER_EXP2 = 19;
	localparam int PER_EXP3 = 21;
	localparam int CNT_W    = 21;

	// State clock is the fast clock divided by this ratio
	localparam int STATE_DIV = 2;

	// Status bits
	localparam int ST_OVF = 0;
	localparam logic [7:0] STAT_RST = 8'h00;

	typedef struct packed {
		logic        en;
		logic [1:0]  per;
		logic        lhr;
		logic        rcon;
	} mode_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

endpackage

// ===== tb/wdog_top_bench.sv
// Self-checking bench for the watchdog supervisor: register port, overflow timing, halt, interrupt.
// Assumes the package register map and period code 00, so one overflow takes 65536 fast clocks.
`timescale 1ns/100ps
`default_nettype none
module wdog_top_bench;
	import wdog_pkg::*;
	logic       clk;
	logic       rst_n;
	logic       halt;
	logic       brel;
	reg_req_t   req;
	logic [7:0] rdata;
	logic [7:0] m;
	logic       ovf;
	logic       rreq;
	logic       irq;
	int         n_fail;
	int         tests_run;
	int         n;

	wdog_top i_wdog_top (
		.CLK_SYS_I     (clk),
		.RESETN_I      (rst_n),
		.CE_I          (1'b1),
		.REG_REQ_I     (req),
		.LIGHT_HALT_I  (halt),
		.BUS_RELEASE_I (brel),
		.REG_RDATA_O   (rdata),
		.OVF_PULSE_O   (ovf),
		.RESET_REQ_O   (rreq),
		.IRQ_O         (irq)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask

	task automatic check1(input string what, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR %s expected %b seen %b", what, exp, got);
			n_fail++;
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge clk);
		req.wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge clk);
		req.rd   <= 1'b0;
		#1 check8(what, exp, rdata);
	endtask

	initial begin
		rst_n = 1'b0;
		halt = 1'b0;
		brel = 1'b1;
		req = '0;
		n_fail = 0;
		tests_run = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(MODE_OFS, MODE_RST, "mode_reset");
		rd(CMD_OFS, 8'h00, "cmd_read");
		wr(12'h03FF, 8'hFF);
		rd(12'h03FF, 8'h00, "unmapped_read");
		rd(STAT_OFS, STAT_RST, "status_reset");
		for (int c = 0; c < 4; c++) begin
			m = 8'h80 | 8'(c << PSL_POS);
			wr(MODE_OFS, m);
			rd(MODE_OFS, m, "mode_period");
		end
		wr(MODE_OFS, 8'hFF);
		rd(MODE_OFS, MODE_WMASK, "mode_mask");
		wr(MODE_OFS, 8'h82);
		wr(MASK_OFS, 8'h01);
		rd(MASK_OFS, 8'h01, "mask_rw");
		// Late clear keeps the whole run inside one overflow period
		repeat (20000) @(posedge clk);
		wr(CMD_OFS, 8'h55);
		wr(CMD_OFS, CMD_CLEAR);
		n = 0;
		while (ovf !== 1'b1 && n < 70000) begin
			@(posedge clk);
			n++;
			halt <= (n >= 100 && n < 1100);
			#1;
		end
		// 2^15 states of two clocks each, plus 1000 halted clocks; bus stays released throughout
		check1("ovf_time", 1'b1, n >= 66520 && n <= 66552);
		check1("reset_req", 1'b1, rreq);
		check1("irq_set", 1'b1, irq);
		@(posedge clk);
		#1 check1("ovf_pulse_len", 1'b0, ovf);
		rd(STAT_OFS, 8'h01, "status_ovf");
		wr(MASK_OFS, 8'h00);
		#1 check1("irq_masked", 1'b0, irq);
		wr(MASK_OFS, 8'h01);
		#1 check1("irq_unmasked", 1'b1, irq);
		wr(STAT_OFS, 8'h01);
		#1 check1("irq_cleared", 1'b0, irq);
		rd(STAT_OFS, 8'h00, "status_clear");
		wr(CMD_OFS, CMD_DISABLE);
		rd(MODE_OFS, 8'h82, "mode_after_disable");
		test_done();
	end
endmodule
`default_nettype wire
